// File: hdl/snv_device.sv
`timescale 1ns/100ps
`default_nettype none
module snv_device #(
  // arbitrary neutral identity word
  parameter logic [31:0] ID_WORD = 32'h5a01_0203
) (
  // link
  snv_link_if.device link,
  // power-up clear, synchronous to the link clock
  input wire logic srst,
  // status view
  output logic [7:0] status
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    snv_pkg::snv_phase_e ph;
    logic [4:0] cnt;
    logic [7:0] opc;
    logic [15:0] sh;
    logic [snv_pkg::ADDR_W-1:0] addr;
    logic [31:0] tx;
    logic tx_on;
    logic spe;
    logic [2:0] spare;
    logic [1:0] bp;
    logic write_enable_latch;
    logic wel_clr_pend;
    logic [1:0] wp_sync;
  } snv_dev_s;

  snv_dev_s q;
  snv_dev_s d;
  logic in_frame;
  logic so_q;
  logic [7:0] mem [snv_pkg::MEM_DEPTH];
  logic mem_we;
  logic [snv_pkg::ADDR_W-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic [snv_pkg::ADDR_W-1:0] next_addr;
  logic [15:0] sh_in;
  logic [4:0] c;
  logic [7:0] stat_now;
  snv_pkg::snv_phase_e ph_cur;

  // ****************************************
  // frame tracking
  // ****************************************
  // the link clock stops outside frames, so the frame flag is dropped by
  // the select line itself; everything else rebuilds on the next first edge
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      in_frame <= 1'b0;
    end else if (link.hold_n) begin
      in_frame <= 1'b1;
    end
  end

  // ****************************************
  // next state on the rising link edge
  // ****************************************
  always_comb begin
    d = q;
    mem_we = 1'b0;
    mem_wa = q.addr;
    mem_wd = q.sh[7:0];
    d.wp_sync = {q.wp_sync[0], link.wp_n};
    ph_cur = in_frame ? q.ph : snv_pkg::PH_OPC;
    c = in_frame ? q.cnt : 5'h00;
    if (!in_frame) begin
      d.tx_on = 1'b0;
      if (q.wel_clr_pend) begin
        d.write_enable_latch = 1'b0;
        d.wel_clr_pend = 1'b0;
      end
    end
    stat_now = {d.spe, d.spare, d.bp, d.write_enable_latch, 1'b0};
    sh_in = {(in_frame ? q.sh[14:0] : 15'h0000), link.si};
    next_addr = q.addr + 15'h0001;
    // hold and deselect freeze the engine; inputs are don't-care then
    if (!link.cs_n && link.hold_n) begin
      d.sh = sh_in;
      c = c + 5'h01;
      d.cnt = c;
      d.ph = ph_cur;
      case (ph_cur)
        snv_pkg::PH_OPC: begin
          if (c == snv_pkg::BITS_BYTE) begin
            d.cnt = 5'h00;
            d.opc = sh_in[7:0];
            case (sh_in[7:0])
              snv_pkg::OP_SET_LATCH: begin
                d.write_enable_latch = 1'b1;
                d.ph = snv_pkg::PH_DONE;
              end
              snv_pkg::OP_CLR_LATCH: begin
                d.write_enable_latch = 1'b0;
                d.ph = snv_pkg::PH_DONE;
              end
              snv_pkg::OP_STAT_RD: begin
                d.tx = {stat_now, 24'h000000};
                d.tx_on = 1'b1;
                d.ph = snv_pkg::PH_SRD;
              end
              snv_pkg::OP_STAT_WR: begin
                d.wel_clr_pend = 1'b1;
                d.ph = snv_pkg::PH_SWR;
              end
              snv_pkg::OP_WRITE: begin
                d.wel_clr_pend = 1'b1;
                d.ph = snv_pkg::PH_ADDR;
              end
              snv_pkg::OP_READ, snv_pkg::OP_FAST_RD: begin
                d.ph = snv_pkg::PH_ADDR;
              end
              snv_pkg::OP_ID_RD: begin
                d.tx = ID_WORD;
                d.tx_on = 1'b1;
                d.ph = snv_pkg::PH_ID;
              end
              default: begin
                d.ph = snv_pkg::PH_IGNORE;
              end
            endcase
          end
        end
        snv_pkg::PH_ADDR: begin
          if (c == snv_pkg::BITS_ADDR) begin
            d.cnt = 5'h00;
            d.addr = sh_in[snv_pkg::ADDR_W-1:0];
            case (q.opc)
              snv_pkg::OP_READ: begin
                d.tx = {mem[sh_in[snv_pkg::ADDR_W-1:0]], 24'h000000};
                d.tx_on = 1'b1;
                d.ph = snv_pkg::PH_RDATA;
              end
              snv_pkg::OP_FAST_RD: d.ph = snv_pkg::PH_DUMMY;
              default: d.ph = snv_pkg::PH_WDATA;
            endcase
          end
        end
        snv_pkg::PH_DUMMY: begin
          if (c == snv_pkg::BITS_BYTE) begin
            d.cnt = 5'h00;
            d.tx = {mem[q.addr], 24'h000000};
            d.tx_on = 1'b1;
            d.ph = snv_pkg::PH_RDATA;
          end
        end
        snv_pkg::PH_RDATA: begin
          if (c == snv_pkg::BITS_BYTE) begin
            d.cnt = 5'h00;
            d.addr = next_addr;
            d.tx = {mem[next_addr], 24'h000000};
          end else begin
            d.tx = {q.tx[30:0], 1'b0};
          end
        end
        snv_pkg::PH_SRD: begin
          // repeats the live status byte for as long as clocks keep coming
          if (c == snv_pkg::BITS_BYTE) begin
            d.cnt = 5'h00;
            d.tx = {stat_now, 24'h000000};
          end else begin
            d.tx = {q.tx[30:0], 1'b0};
          end
        end
        snv_pkg::PH_ID: begin
          // the last id bit is copied in so it stays on the line afterwards
          d.cnt = 5'h00;
          d.tx = {q.tx[30:0], q.tx[0]};
        end
        snv_pkg::PH_WDATA: begin
          if (c == snv_pkg::BITS_BYTE) begin
            d.cnt = 5'h00;
            d.addr = next_addr;
            // no busy time: the byte lands on this very edge
            mem_we = q.write_enable_latch && !snv_pkg::addr_shielded(q.bp, q.addr);
            mem_wd = sh_in[7:0];
          end
        end
        snv_pkg::PH_SWR: begin
          if (c == snv_pkg::BITS_BYTE) begin
            d.cnt = 5'h00;
            d.ph = snv_pkg::PH_DONE;
            if (snv_pkg::status_writable(q.write_enable_latch, q.spe, q.wp_sync[1])) begin
              d.spe = sh_in[snv_pkg::SR_SPE];
              d.spare = sh_in[snv_pkg::SR_SPARE_HI:snv_pkg::SR_SPARE_LO];
              d.bp = sh_in[snv_pkg::SR_BP_HI:snv_pkg::SR_BP_LO];
            end
          end
        end
        default: begin
          d.cnt = 5'h00;
        end
      endcase
    end
    if (srst) begin
      d = '0;
      d.ph = snv_pkg::PH_OPC;
      d.spare = snv_pkg::SPARE_RESET;
      d.bp = snv_pkg::BP_RESET;
      d.write_enable_latch = 1'b0;
    end
  end

  always_ff @(posedge link.sck) begin
    q <= d;
  end

  always_ff @(posedge link.sck) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // ****************************************
  // serial output
  // ****************************************
  always_ff @(negedge link.sck) begin
    so_q <= q.tx[31];
  end

  // driven only while selected, not held and in a reading phase
  assign link.so_o = so_q;
  assign link.so_oe = in_frame & q.tx_on & ~link.cs_n & link.hold_n;
  assign status = {q.spe, q.spare, q.bp, q.write_enable_latch & ~q.wel_clr_pend, 1'b0};

endmodule
`default_nettype wire

// File: hdl/snv_pkg.sv
// Contract
// - deselected: standby, output off, inputs ignored
// - master lowers select before opcode
// - hold low pauses transfer, output off
// - master keeps select low during hold
// - sample input rising, change output falling
// - master sends opcode, address, data on input
// - array and status data leave on output
// - only clock modes 0 and 3
// - device is slave only, separate selects
// - array of 32768 bytes, each addressable
// - bit 7 status protect, with pin
// - bits 6..4 spare storage, zero initially
// - bits 3..2 block protect, read/write
// - bit 1 latch: set/clear commands only
// - latch clear refuses all writes
// - latch clears: power-up, clear command, write end
// - bit 0 reads zero, not writable
// - clock limits 25 MHz read, 33 MHz others
// - memory write has no busy time
// - eight opcode values as listed
// - block protect 00..11 shields none/quarter/half/all
// - write permission from latch, protect bit, pin
// - 16-bit address, top ignored, auto-increment, wrap
package snv_pkg;

  // ****************************************
  // array and opcodes
  // ****************************************
  localparam int ADDR_W = 15;
  localparam int MEM_DEPTH = 32768;
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_ID_RD = 8'h9f;
  localparam logic [7:0] OP_FAST_RD = 8'h0b;

  // ****************************************
  // status layout and reset values
  // ****************************************
  localparam int SR_SPE = 7;
  localparam int SR_SPARE_HI = 6;
  localparam int SR_SPARE_LO = 4;
  localparam int SR_BP_HI = 3;
  localparam int SR_BP_LO = 2;
  localparam int SR_WEL = 1;
  localparam logic [2:0] SPARE_RESET = 3'h0;
  localparam logic [1:0] BP_RESET = 2'h0;
  localparam logic [ADDR_W-1:0] BOUND_QUARTER = 15'h6000;
  localparam logic [ADDR_W-1:0] BOUND_HALF = 15'h4000;

  // ****************************************
  // frame bit counts and host timing
  // ****************************************
  localparam logic [4:0] BITS_BYTE = 5'h08;
  localparam logic [4:0] BITS_ADDR = 5'h10;
  localparam int SYS_PERIOD_NS = 25;
  localparam int SCK_PERIOD_NS = 200;
  localparam logic [2:0] HALF_CYC = 3'(SCK_PERIOD_NS / (2 * SYS_PERIOD_NS));

  typedef enum logic [3:0] {
    PH_OPC, PH_ADDR, PH_DUMMY, PH_WDATA, PH_RDATA, PH_SRD, PH_SWR, PH_ID, PH_DONE, PH_IGNORE
  } snv_phase_e;

  typedef enum logic [2:0] {HS_IDLE, HS_LEAD, HS_LOW, HS_HIGH, HS_HOLD, HS_TAIL} snv_host_e;

  function automatic logic addr_shielded(input logic [1:0] bp, input logic [ADDR_W-1:0] a);
    case (bp)
      2'h0: addr_shielded = 1'b0;
      2'h1: addr_shielded = (a >= BOUND_QUARTER);
      2'h2: addr_shielded = (a >= BOUND_HALF);
      default: addr_shielded = 1'b1;
    endcase
  endfunction

  function automatic logic status_writable(input logic write_enable_latch, input logic spe, input logic wp_n);
    status_writable = write_enable_latch & (~spe | wp_n);
  endfunction

endpackage

// File: hdl/snv_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface snv_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic hold_n;
  logic wp_n;
  logic so_o;
  logic so_oe;
  logic so_line;

  // released line reads high, as with a pull-up on the board
  assign so_line = so_oe ? so_o : 1'b1;

  modport device (
    input cs_n, sck, si, hold_n, wp_n,
    output so_o, so_oe
  );

  modport host (
    output cs_n, sck, si, hold_n, wp_n,
    input so_line
  );
endinterface
`default_nettype wire

// File: hdl/snv_host.sv
`timescale 1ns/100ps
`default_nettype none
module snv_host (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // link
  snv_link_if.host link,
  // pin levels
  input wire logic mode3,
  input wire logic wp_level,
  input wire logic hold_req,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_opcode,
  input wire logic [15:0] cmd_addr,
  input wire logic cmd_addr_en,
  input wire logic cmd_dummy_en,
  input wire logic [7:0] cmd_len,
  // data
  input wire logic [7:0] tx_data,
  output logic tx_take,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic busy
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    snv_pkg::snv_host_e st;
    logic [2:0] div;
    logic sck;
    logic cs_n;
    logic si;
    logic hold_n;
    logic wp_n;
    logic idle_hi;
    logic [31:0] hdr;
    logic [2:0] hdr_n;
    logic [8:0] left;
    logic [7:0] osr;
    logic [2:0] bitn;
    logic cur_data;
    logic [7:0] isr;
    logic [7:0] rx_data;
    logic rx_valid;
    logic tx_take;
    logic [1:0] so_sync;
  } snv_host_s;

  snv_host_s q;
  snv_host_s d;
  logic half_done;

  always_comb begin
    d = q;
    d.rx_valid = 1'b0;
    d.tx_take = 1'b0;
    d.wp_n = wp_level;
    d.so_sync = {q.so_sync[0], link.so_line};
    half_done = (q.div == snv_pkg::HALF_CYC - 3'h1);
    d.div = half_done ? 3'h0 : q.div + 3'h1;
    case (q.st)
      snv_pkg::HS_IDLE: begin
        d.div = 3'h0;
        d.cs_n = 1'b1;
        d.idle_hi = mode3;
        d.sck = mode3;
        if (cmd_valid) begin
          d.hdr = cmd_addr_en ? {cmd_opcode, cmd_addr, 8'h00} : {cmd_opcode, 24'h000000};
          d.hdr_n = 3'h1 + (cmd_addr_en ? 3'h2 : 3'h0) + (cmd_dummy_en ? 3'h1 : 3'h0);
          d.left = 9'(d.hdr_n) + 9'(cmd_len);
          d.cs_n = 1'b0;
          d.st = snv_pkg::HS_LEAD;
        end
      end
      snv_pkg::HS_LEAD, snv_pkg::HS_HIGH: begin
        if (half_done) begin
          if (q.st == snv_pkg::HS_HIGH && q.bitn != 3'h7) begin
            d.bitn = q.bitn + 3'h1;
            d.osr = {q.osr[6:0], 1'b0};
          end else begin
            if (q.st == snv_pkg::HS_HIGH) begin
              d.left = q.left - 9'h001;
              d.rx_valid = q.cur_data;
              d.rx_data = q.isr;
            end
            d.bitn = 3'h0;
            if (q.hdr_n != 3'h0) begin
              d.osr = q.hdr[31:24];
              d.hdr = {q.hdr[23:0], 8'h00};
              d.hdr_n = q.hdr_n - 3'h1;
              d.cur_data = 1'b0;
            end else begin
              d.osr = tx_data;
              d.tx_take = (d.left != 9'h000);
              d.cur_data = 1'b1;
            end
          end
          if (q.st == snv_pkg::HS_HIGH && d.left == 9'h000) begin
            d.sck = q.idle_hi;
            d.st = snv_pkg::HS_TAIL;
          end else begin
            d.sck = 1'b0;
            d.si = d.osr[7];
            // hold only enters with the clock low and leaves with it low
            d.hold_n = ~hold_req;
            d.st = hold_req ? snv_pkg::HS_HOLD : snv_pkg::HS_LOW;
          end
        end
      end
      snv_pkg::HS_HOLD: begin
        d.div = 3'h0;
        if (!hold_req) begin
          d.hold_n = 1'b1;
          d.st = snv_pkg::HS_LOW;
        end
      end
      snv_pkg::HS_LOW: begin
        if (half_done) begin
          // device moved its output a half period ago, past the two sync flops
          d.isr = {q.isr[6:0], q.so_sync[1]};
          d.sck = 1'b1;
          d.st = snv_pkg::HS_HIGH;
        end
      end
      snv_pkg::HS_TAIL: begin
        if (half_done) begin
          d.cs_n = 1'b1;
          d.st = snv_pkg::HS_IDLE;
        end
      end
      default: begin
        d.st = snv_pkg::HS_IDLE;
      end
    endcase
    if (srst) begin
      d = '0;
      d.st = snv_pkg::HS_IDLE;
      d.cs_n = 1'b1;
      d.hold_n = 1'b1;
      d.wp_n = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    q <= d;
  end

  // ****************************************
  // outputs
  // ****************************************
  // a fixed 200 ns link period stays under both clock limits
  assign link.sck = q.sck;
  assign link.cs_n = q.cs_n;
  assign link.si = q.si;
  assign link.hold_n = q.hold_n;
  assign link.wp_n = q.wp_n;
  assign cmd_ready = (q.st == snv_pkg::HS_IDLE);
  assign busy = (q.st != snv_pkg::HS_IDLE);
  assign tx_take = q.tx_take;
  assign rx_data = q.rx_data;
  assign rx_valid = q.rx_valid;

endmodule
`default_nettype wire

// File: hdl/snv_pad_fix.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// File: verification/snv_link_props.sv
`timescale 1ns/100ps
`default_nettype none
module snv_link_props (
  // host domain
  input wire logic sys_clk,
  input wire logic srst,
  // link
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic so_o,
  input wire logic so_oe,
  input wire logic so_line
);
  // ********
  // link checks
  // ********
  // the link clock is made from sys_clk, so sampling there sees every edge
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  property p_desel_quiet;
    cs_n |-> !so_oe && so_line;
  endproperty
  a_desel_quiet: assert property (p_desel_quiet)
    else $error("output driven while deselected");

  property p_hold_quiet;
    !hold_n |-> !so_oe;
  endproperty
  a_hold_quiet: assert property (p_hold_quiet)
    else $error("output driven during hold");

  property p_hold_sel;
    !hold_n |-> !cs_n;
  endproperty
  a_hold_sel: assert property (p_hold_sel)
    else $error("hold without select");

  property p_so_fall;
    $changed(so_o) |-> $fell(sck);
  endproperty
  a_so_fall: assert property (p_so_fall)
    else $error("output moved off a falling clock");

  property p_si_hold;
    !cs_n && sck && $past(sck) |-> $stable(si);
  endproperty
  a_si_hold: assert property (p_si_hold)
    else $error("input moved in high half");

  property p_sel_lead;
    $fell(cs_n) |=> $stable(sck) [*3];
  endproperty
  a_sel_lead: assert property (p_sel_lead)
    else $error("clock moved too soon after select");

  property p_high_half;
    $rose(sck) && !cs_n |-> sck [*4];
  endproperty
  a_high_half: assert property (p_high_half)
    else $error("high half too short");

  property p_low_half;
    $fell(sck) && !cs_n |-> !sck [*4];
  endproperty
  a_low_half: assert property (p_low_half)
    else $error("low half too short");

  // a mode switch moves the idle level once; a second move would be a stray edge
  property p_idle_still;
    cs_n && $past(cs_n) && $changed(sck) |=> (!cs_n || $stable(sck)) [*8];
  endproperty
  a_idle_still: assert property (p_idle_still)
    else $error("clock runs outside a frame");

  property p_wp_steady;
    !cs_n && !$past(cs_n) |-> $stable(wp_n);
  endproperty
  a_wp_steady: assert property (p_wp_steady)
    else $error("protect pin moved inside a frame");
endmodule
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  // arbitrary neutral identity word
  localparam logic [31:0] ID = 32'h3c4d5e6f;
  logic sys_clk, srst, dev_srst, mode3, wp_level, hold_req, cmd_valid;
  logic cmd_addr_en, cmd_dummy_en, cmd_ready, tx_take, rx_valid, busy;
  logic [7:0] cmd_opcode, cmd_len, tx_data, rx_data, status;
  logic [15:0] cmd_addr;
  logic [7:0] txb [0:7];
  logic [7:0] rxq [$];
  int ti, fail_count, checked;

  snv_link_if link();
  snv_device #(.ID_WORD(ID)) u_snv_device(.link(link), .srst(dev_srst), .status(status));
  snv_host u_snv_host(.sys_clk(sys_clk), .srst(srst), .link(link), .mode3(mode3),
    .wp_level(wp_level), .hold_req(hold_req), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr), .cmd_addr_en(cmd_addr_en),
    .cmd_dummy_en(cmd_dummy_en), .cmd_len(cmd_len), .tx_data(tx_data), .tx_take(tx_take),
    .rx_data(rx_data), .rx_valid(rx_valid), .busy(busy));
  snv_link_props u_props(.sys_clk(sys_clk), .srst(srst), .cs_n(link.cs_n), .sck(link.sck),
    .si(link.si), .hold_n(link.hold_n), .wp_n(link.wp_n), .so_o(link.so_o),
    .so_oe(link.so_oe), .so_line(link.so_line));

  // ********
  // clock, data feed, helpers
  // ********
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (tx_take === 1'b1) begin
      ti <= ti + 1;
      tx_data <= txb[ti + 1];
    end
    if (rx_valid === 1'b1) begin
      rxq.push_back(rx_data);
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic results();
    if (fail_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic run(input logic [7:0] op, input logic [15:0] a, input logic ae,
      input logic de, input logic [7:0] n);
    int k;
    @(posedge sys_clk);
    rxq.delete();
    ti <= 0;
    tx_data <= txb[0];
    cmd_valid <= 1'b1;
    cmd_opcode <= op;
    cmd_addr <= a;
    cmd_addr_en <= ae;
    cmd_dummy_en <= de;
    cmd_len <= n;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    k = 0;
    do begin
      @(posedge sys_clk);
      #1;
      k++;
    end while (busy !== 1'b0 && k < 3000);
    if (k >= 3000) begin
      chk("busy", {31'h0, busy}, 32'h0);
    end
    chk("ready", {31'h0, cmd_ready}, 32'h1);
  endtask

  task automatic wen();
    run(snv_pkg::OP_SET_LATCH, 16'h0, 1'b0, 1'b0, 8'h0);
  endtask

  task automatic stw(input logic [7:0] v);
    wen();
    txb[0] = v;
    run(snv_pkg::OP_STAT_WR, 16'h0, 1'b0, 1'b0, 8'h1);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input int n);
    wen();
    for (int i = 0; i < n; i++) txb[i] = d + 8'(i);
    run(snv_pkg::OP_WRITE, a, 1'b1, 1'b0, 8'(n));
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] n);
    run(snv_pkg::OP_READ, a, 1'b1, 1'b0, n);
  endtask

  // ********
  // scenarios
  // ********
  task automatic t_latch();
    chk("status_reset", status, 8'h00);
    wen();
    chk("wel_set", status, 8'h02);
    run(snv_pkg::OP_STAT_RD, 16'h0, 1'b0, 1'b0, 8'h2);
    chk("stat_rd0", rxq[0], 8'h02);
    chk("stat_rd1", rxq[1], 8'h02);
    run(8'h77, 16'h0, 1'b0, 1'b0, 8'h2);
    chk("bad_op_line", rxq[0], 8'hff);
    chk("bad_op_wel", status, 8'h02);
    run(snv_pkg::OP_CLR_LATCH, 16'h0, 1'b0, 1'b0, 8'h0);
    chk("wel_clr", status, 8'h00);
  endtask

  task automatic t_status();
    stw(8'hff);
    chk("stw_all", status, 8'hfc);
    run(snv_pkg::OP_STAT_RD, 16'h0, 1'b0, 1'b0, 8'h1);
    chk("stw_rd", rxq[0], 8'hfc);
    @(posedge sys_clk);
    wp_level <= 1'b0;
    stw(8'h00);
    chk("stw_locked", status, 8'hfc);
    @(posedge sys_clk);
    wp_level <= 1'b1;
    stw(8'h00);
    chk("stw_open", status, 8'h00);
    txb[0] = 8'h30;
    run(snv_pkg::OP_STAT_WR, 16'h0, 1'b0, 1'b0, 8'h1);
    chk("stw_no_wel", status, 8'h00);
  endtask

  task automatic t_array();
    // top address bit set on purpose, and the burst crosses the wrap
    wr(16'hfffe, 8'ha1, 3);
    rd(16'h7ffe, 8'h3);
    for (int i = 0; i < 3; i++) chk("rd_wrap", rxq[i], 8'ha1 + i);
    run(snv_pkg::OP_FAST_RD, 16'h0000, 1'b1, 1'b1, 8'h1);
    chk("fast_rd", rxq[0], 8'ha3);
    txb[0] = 8'h55;
    run(snv_pkg::OP_WRITE, 16'h0000, 1'b1, 1'b0, 8'h1);
    rd(16'h0000, 8'h1);
    chk("wr_no_wel", rxq[0], 8'ha3);
    @(posedge sys_clk);
    mode3 <= 1'b1;
    rd(16'h7fff, 8'h1);
    chk("mode3_rd", rxq[0], 8'ha2);
    @(posedge sys_clk);
    mode3 <= 1'b0;
  endtask

  task automatic t_protect();
    for (int bp = 1; bp < 4; bp++) begin
      stw(8'h00);
      wr(16'h3fff, 8'he0, 2);
      wr(16'h5fff, 8'he0, 2);
      stw(8'(bp << 2));
      wr(16'h3fff, 8'h10, 2);
      wr(16'h5fff, 8'h10, 2);
      rd(16'h3fff, 8'h2);
      chk("bp_3fff", rxq[0], bp == 3 ? 8'he0 : 8'h10);
      chk("bp_4000", rxq[1], bp >= 2 ? 8'he1 : 8'h11);
      rd(16'h5fff, 8'h2);
      chk("bp_5fff", rxq[0], bp >= 2 ? 8'he0 : 8'h10);
      chk("bp_6000", rxq[1], 8'he1);
    end
    stw(8'h00);
  endtask

  task automatic t_id();
    run(snv_pkg::OP_ID_RD, 16'h0, 1'b0, 1'b0, 8'h5);
    for (int i = 0; i < 4; i++) chk("id", rxq[i], ID[31 - 8 * i -: 8]);
    chk("id_tail", rxq[4], {8{ID[0]}});
  endtask

  task automatic t_hold();
    fork
      rd(16'h7ffe, 8'h3);
      begin
        // lands inside the data bytes, after the header
        repeat (230) @(posedge sys_clk);
        hold_req <= 1'b1;
        repeat (40) @(posedge sys_clk);
        hold_req <= 1'b0;
      end
    join
    for (int i = 0; i < 3; i++) chk("hold_rd", rxq[i], 8'ha1 + i);
  endtask

  initial begin
    repeat (40000) @(posedge sys_clk);
    fail_count++;
    results();
  end

  initial begin
    srst = 1'b1;
    dev_srst = 1'b1;
    mode3 = 1'b0;
    wp_level = 1'b1;
    hold_req = 1'b0;
    cmd_valid = 1'b0;
    cmd_opcode = 8'h00;
    cmd_addr = 16'h0;
    cmd_addr_en = 1'b0;
    cmd_dummy_en = 1'b0;
    cmd_len = 8'h00;
    tx_data = 8'h00;
    ti = 0;
    fail_count = 0;
    checked = 0;
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    // the device clears on link clock edges, so a frame runs under its reset
    run(snv_pkg::OP_CLR_LATCH, 16'h0, 1'b0, 1'b0, 8'h0);
    @(posedge sys_clk);
    dev_srst <= 1'b0;
    t_latch();
    t_status();
    t_array();
    t_protect();
    t_id();
    t_hold();
    results();
  end
endmodule
`default_nettype wire
